// *** rtl/spac_pkg.sv ***
// Package of offsets, field positions, reset values and timing for the block.
package spac_pkg;
   localparam int          ADDR_W          = 28;
   localparam logic [27:0] OFS_MODEM       = 28'hc000006;
   localparam logic [27:0] OFS_SPARE       = 28'hc000007;
   localparam logic [27:0] OFS_IRSEL       = 28'hc000008;
   localparam logic [27:0] OFS_SRESET      = 28'hc000009;
   localparam logic [27:0] OFS_ECHO        = 28'hc00000a;
   localparam logic [27:0] OFS_ACTMSK      = 28'hc00000c;
   localparam logic [27:0] OFS_PERIOD      = 28'hc00000e;
   localparam logic [27:0] OFS_IRQ_STAT    = 28'hc000010;
   localparam logic [27:0] OFS_IRQ_MASK    = 28'hc000011;
   // Bits that keep written state; all other bits read zero.
   localparam logic [7:0]  IRSEL_WMASK     = 8'h01;
   localparam logic [7:0]  BIT0_WMASK      = 8'h01;
   localparam logic [7:0]  ACTMSK_WMASK    = 8'h3d;
   localparam logic [7:0]  RESET_VAL       = 8'h00;
   localparam int          POS_ROUTE       = 0;
   localparam int          POS_SRESET      = 0;
   localparam int          POS_ECHO        = 0;
   localparam int          POS_TXWR_MSK    = 0;
   localparam int          POS_DTR_MSK     = 2;
   localparam int          POS_DCD_MSK     = 3;
   localparam int          POS_RTS_MSK     = 4;
   localparam int          POS_RXD_MSK     = 5;
   localparam int          POS_IRQ_MODEM   = 0;
   localparam int          POS_IRQ_TIMEOUT = 1;
   // Activity timer unit: 30.5 us, held in ns.
   localparam real         UNIT_NS         = 30500.0;
   localparam real         CLK_NS          = 50.0;
   localparam int          UNIT_CYC        = int'(UNIT_NS / CLK_NS);
endpackage : spac_pkg

// *** rtl/spac_edge_flag.sv ***
// Synchroniser with change flag for one modem control input.
module spac_edge_flag
   import spac_pkg::*;
(
   input  wire logic clk_i,
   input  wire logic rst_i,
   input  wire logic pin_i,
   input  wire logic clear_i,
   output logic      level_o,
   output logic      change_o
);
   logic meta_q;
   logic sync_q;
   logic prev_q;
   logic chg_q;

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         meta_q <= 1'b1;
         sync_q <= 1'b1;
         prev_q <= 1'b1;
      end else begin
         meta_q <= pin_i;
         sync_q <= meta_q;
         prev_q <= sync_q;
      end
   end

   // A change in the clearing cycle still sets the flag.
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         chg_q <= 1'b0;
      end else if (sync_q != prev_q) begin
         chg_q <= 1'b1; // [RL2]
      end else if (clear_i) begin
         chg_q <= 1'b0; // [RL3]
      end
   end

   assign level_o  = ~sync_q; // [RL1]
   assign change_o = chg_q;
endmodule // spac_edge_flag

// *** rtl/spac_aux_regs.sv ***
// Auxiliary control registers of the second serial port.
// Contract
// RL1: Bits 7..4 read inverted live modem inputs.
// RL2: Bits 3..0 set on input level change.
// RL3: Reading modem status clears change bits.
// RL4: Free 8-bit spare byte, resets zero.
// RL5: Route bit selects infrared or wired pins.
// RL6: Reserved bits read zero; software writes zero.
// RL7: Soft reset bit holds port in reset.
// RL8: Echo mask bit: 1 normal, 0 echo.
// RL9: Set mask bit blocks timer retrigger.
// RL10: Mask bits map rx, rts, dcd, dtr, tx.
// RL11: Timer unit 30.5 us; zero disables.
// RL12: Any change bit raises modem interrupt.
//
// The strobed register port is this design's own decision.
module spac_aux_regs
   import spac_pkg::*;
#(
   parameter int UNIT_CYCLES = UNIT_CYC
)
(
   input  wire logic              CLOCK_I,
   input  wire logic              RESET_I,
   input  wire logic [ADDR_W-1:0] ADDR_I,
   input  wire logic [7:0]        WDATA_I,
   input  wire logic              WR_I,
   input  wire logic              RD_I,
   output logic      [7:0]        RDATA_O,
   input  wire logic              CARRIER_DETECT_N_I,
   input  wire logic              BELL_INDICATOR_N_I,
   input  wire logic              PEER_READY_N_I,
   input  wire logic              CLEAR_TO_SEND_N_I,
   input  wire logic              RX_LINE_EDGE_I,
   input  wire logic              REQUEST_SEND_EDGE_I,
   input  wire logic              CARRIER_EDGE_I,
   input  wire logic              TERMINAL_READY_EDGE_I,
   input  wire logic              TX_BUFFER_WRITE_I,
   input  wire logic              PORT_IRQ_ENABLE_I,
   output logic                   INFRARED_ROUTE_O,
   output logic                   PORT_SOFT_RESET_O,
   output logic                   ECHO_MASK_O,
   output logic                   MODEM_IRQ_O,
   output logic                   ACTIVITY_TIMEOUT_O,
   output logic                   IRQ_O
);
   logic [7:0]  spare_q;
   logic [7:0]  irsel_q;
   logic [7:0]  sreset_q;
   logic [7:0]  echo_q;
   logic [7:0]  actmsk_q;
   logic [7:0]  period_q;
   logic [1:0]  irq_stat;
   logic        irq_modem_q;
   logic        irq_timeout_q;
   logic [1:0]  irq_mask_q;
   logic [7:0]  rdata_q;
   logic [3:0]  level;
   logic [3:0]  change;
   logic [3:0]  pins;
   logic        modem_rd;
   logic        retrigger;
   logic [15:0] unit_cnt_q;
   logic        unit_tick;
   logic [7:0]  units_q;
   logic        timeout_ev;
   logic [7:0]  rdata_d;
   logic [3:0]  change_q;
   logic        modem_event;
   logic        wr_spare;
   logic        wr_irsel;
   logic        wr_sreset;
   logic        wr_echo;
   logic        wr_actmsk;
   logic        wr_period;
   logic        wr_irq_mask;
   logic        rd_irq_stat;
   logic        timer_on;

   // Order: carrier, bell, peer ready, clear to send (bits 3..0).
   assign pins     = {CARRIER_DETECT_N_I, BELL_INDICATOR_N_I,
                      PEER_READY_N_I, CLEAR_TO_SEND_N_I};
   assign modem_rd = RD_I && (ADDR_I == OFS_MODEM);

   // One decode per register; an unmapped address misses every enable.
   assign wr_spare    = WR_I && (ADDR_I == OFS_SPARE);
   assign wr_irsel    = WR_I && (ADDR_I == OFS_IRSEL);
   assign wr_sreset   = WR_I && (ADDR_I == OFS_SRESET);
   assign wr_echo     = WR_I && (ADDR_I == OFS_ECHO);
   assign wr_actmsk   = WR_I && (ADDR_I == OFS_ACTMSK);
   assign wr_period   = WR_I && (ADDR_I == OFS_PERIOD);
   assign wr_irq_mask = WR_I && (ADDR_I == OFS_IRQ_MASK);
   assign rd_irq_stat = RD_I && (ADDR_I == OFS_IRQ_STAT);
   assign timer_on    = (period_q != 8'h00);

   for (genvar g = 0; g < 4; g++) begin : g_line
      spac_edge_flag u_flag (
         .clk_i    (CLOCK_I),
         .rst_i    (RESET_I),
         .pin_i    (pins[g]),
         .clear_i  (modem_rd),
         .level_o  (level[g]),
         .change_o (change[g])
      );
   end

   always_ff @(posedge CLOCK_I or posedge RESET_I) begin
      if (RESET_I) begin
         spare_q <= RESET_VAL;
      end else if (wr_spare) begin
         spare_q <= WDATA_I; // [RL4]
      end
   end

   always_ff @(posedge CLOCK_I or posedge RESET_I) begin
      if (RESET_I) begin
         irsel_q <= RESET_VAL;
      end else if (wr_irsel) begin
         irsel_q <= WDATA_I & IRSEL_WMASK; // [RL5] [RL6]
      end
   end

   always_ff @(posedge CLOCK_I or posedge RESET_I) begin
      if (RESET_I) begin
         sreset_q <= RESET_VAL;
      end else if (wr_sreset) begin
         sreset_q <= WDATA_I & BIT0_WMASK; // [RL7] [RL6]
      end
   end

   always_ff @(posedge CLOCK_I or posedge RESET_I) begin
      if (RESET_I) begin
         echo_q <= RESET_VAL;
      end else if (wr_echo) begin
         echo_q <= WDATA_I & BIT0_WMASK; // [RL8] [RL6]
      end
   end

   always_ff @(posedge CLOCK_I or posedge RESET_I) begin
      if (RESET_I) begin
         actmsk_q <= RESET_VAL;
      end else if (wr_actmsk) begin
         actmsk_q <= WDATA_I & ACTMSK_WMASK; // [RL6]
      end
   end

   always_ff @(posedge CLOCK_I or posedge RESET_I) begin
      if (RESET_I) begin
         period_q <= RESET_VAL;
      end else if (wr_period) begin
         period_q <= WDATA_I;
      end
   end

   always_ff @(posedge CLOCK_I or posedge RESET_I) begin
      if (RESET_I) begin
         irq_mask_q <= 2'h0;
      end else if (wr_irq_mask) begin
         irq_mask_q <= WDATA_I[1:0];
      end
   end

   // An unmasked event restarts the activity timer.
   assign retrigger =
      (RX_LINE_EDGE_I        && !actmsk_q[POS_RXD_MSK])  ||
      (REQUEST_SEND_EDGE_I   && !actmsk_q[POS_RTS_MSK])  ||
      (CARRIER_EDGE_I        && !actmsk_q[POS_DCD_MSK])  ||
      (TERMINAL_READY_EDGE_I && !actmsk_q[POS_DTR_MSK])  ||
      (TX_BUFFER_WRITE_I     && !actmsk_q[POS_TXWR_MSK]); // [RL9] [RL10]

   // Prescaler for the 30.5 us unit; a retrigger realigns it.
   assign unit_tick = (unit_cnt_q == 16'(UNIT_CYCLES - 1));

   always_ff @(posedge CLOCK_I or posedge RESET_I) begin
      if (RESET_I) begin
         unit_cnt_q <= 16'h0000;
      end else if (retrigger || unit_tick || !timer_on) begin
         unit_cnt_q <= 16'h0000;
      end else begin
         unit_cnt_q <= unit_cnt_q + 16'h0001;
      end
   end

   // Counts down units; the timeout fires once per idle period.
   // A retrigger in the last cycle restarts the count instead of expiring.
   assign timeout_ev = unit_tick && (units_q == 8'h01) && !retrigger;

   always_ff @(posedge CLOCK_I or posedge RESET_I) begin
      if (RESET_I) begin
         units_q <= 8'h00;
      end else if (!timer_on) begin
         units_q <= 8'h00; // [RL11]
      end else if (retrigger) begin
         units_q <= period_q; // [RL11]
      end else if (unit_tick && units_q != 8'h00) begin
         units_q <= units_q - 8'h01;
      end
   end

   // The summary flag takes the rise of a change bit as its event, so a
   // status read clears it even while change bits are still pending.
   always_ff @(posedge CLOCK_I or posedge RESET_I) begin
      if (RESET_I) begin
         change_q <= 4'h0;
      end else begin
         change_q <= change;
      end
   end

   assign modem_event = |(change & ~change_q);

   // Set beats the clearing read in the same cycle.
   always_ff @(posedge CLOCK_I or posedge RESET_I) begin
      if (RESET_I) begin
         irq_modem_q <= 1'b0;
      end else if (modem_event) begin
         irq_modem_q <= 1'b1; // [RL12]
      end else if (rd_irq_stat) begin
         irq_modem_q <= 1'b0;
      end
   end

   always_ff @(posedge CLOCK_I or posedge RESET_I) begin
      if (RESET_I) begin
         irq_timeout_q <= 1'b0;
      end else if (timeout_ev) begin
         irq_timeout_q <= 1'b1;
      end else if (rd_irq_stat) begin
         irq_timeout_q <= 1'b0;
      end
   end

   assign irq_stat[POS_IRQ_MODEM]   = irq_modem_q;
   assign irq_stat[POS_IRQ_TIMEOUT] = irq_timeout_q;

   always_comb begin
      rdata_d = 8'h00;
      unique case (ADDR_I)
         OFS_MODEM:    rdata_d = {level, change}; // [RL1] [RL3]
         OFS_SPARE:    rdata_d = spare_q;
         OFS_IRSEL:    rdata_d = irsel_q;
         OFS_SRESET:   rdata_d = sreset_q;
         OFS_ECHO:     rdata_d = echo_q;
         OFS_ACTMSK:   rdata_d = actmsk_q;
         OFS_PERIOD:   rdata_d = period_q;
         OFS_IRQ_STAT: rdata_d = {6'h00, irq_stat};
         OFS_IRQ_MASK: rdata_d = {6'h00, irq_mask_q};
         default:      rdata_d = 8'h00;
      endcase
   end

   // Read data stand only in the cycle after the strobe.
   always_ff @(posedge CLOCK_I or posedge RESET_I) begin
      if (RESET_I) begin
         rdata_q <= 8'h00;
      end else if (RD_I) begin
         rdata_q <= rdata_d;
      end else begin
         rdata_q <= 8'h00;
      end
   end

   assign RDATA_O            = rdata_q;
   assign INFRARED_ROUTE_O   = irsel_q[POS_ROUTE]; // [RL5]
   assign PORT_SOFT_RESET_O  = sreset_q[POS_SRESET]; // [RL7]
   assign ECHO_MASK_O        = echo_q[POS_ECHO]; // [RL8]
   assign MODEM_IRQ_O        = (|change) && PORT_IRQ_ENABLE_I; // [RL12]
   assign ACTIVITY_TIMEOUT_O = timeout_ev;
   assign IRQ_O              = |(irq_stat & irq_mask_q);
endmodule // spac_aux_regs

// *** test/spac_aux_asserts.sv ***
// Checker of the auxiliary register block, bound to its top module.
module spac_aux_asserts
   import spac_pkg::*;
(
   input wire logic              CLOCK_I,
   input wire logic              RESET_I,
   input wire logic [ADDR_W-1:0] ADDR_I,
   input wire logic [7:0]        WDATA_I,
   input wire logic              WR_I,
   input wire logic              RD_I,
   input wire logic [7:0]        RDATA_O,
   input wire logic              CARRIER_DETECT_N_I,
   input wire logic              BELL_INDICATOR_N_I,
   input wire logic              PEER_READY_N_I,
   input wire logic              CLEAR_TO_SEND_N_I,
   input wire logic              PORT_IRQ_ENABLE_I,
   input wire logic              INFRARED_ROUTE_O,
   input wire logic              PORT_SOFT_RESET_O,
   input wire logic              ECHO_MASK_O,
   input wire logic              MODEM_IRQ_O,
   input wire logic              ACTIVITY_TIMEOUT_O
);
   timeunit 1ns;
   timeprecision 1ns;
   wire logic [3:0] pins = {CARRIER_DETECT_N_I, BELL_INDICATOR_N_I,
                            PEER_READY_N_I, CLEAR_TO_SEND_N_I};
   wire logic       rd_ms = RD_I && ADDR_I == OFS_MODEM;
   default clocking @(posedge CLOCK_I); endclocking
   default disable iff (RESET_I);
   // Six quiet cycles cover the two-flop synchroniser and the compare.
   sequence s_quiet_read;
      $stable(pins) [*6] ##0 rd_ms;
   endsequence
   a_level_live: assert property (
      s_quiet_read |=> RDATA_O[7:4] == ~$past(pins)) else $error("level");
   a_change_clear: assert property (
      s_quiet_read ##2 rd_ms |=> RDATA_O[3:0] == 4'h0) else $error("clear");
   a_change_irq: assert property (
      $changed(pins) ##1 (PORT_IRQ_ENABLE_I && !rd_ms) [*4] |-> MODEM_IRQ_O)
      else $error("change not flagged");
   a_irq_gate: assert property (
      !PORT_IRQ_ENABLE_I |-> !MODEM_IRQ_O) else $error("irq not gated");
   a_route_write: assert property (
      WR_I && ADDR_I == OFS_IRSEL |=> INFRARED_ROUTE_O == $past(WDATA_I[0]))
      else $error("route");
   a_reset_write: assert property (
      WR_I && ADDR_I == OFS_SRESET |=> PORT_SOFT_RESET_O == $past(WDATA_I[0]))
      else $error("soft reset");
   a_echo_write: assert property (
      WR_I && ADDR_I == OFS_ECHO |=> ECHO_MASK_O == $past(WDATA_I[0]))
      else $error("echo");
   a_ctl_hold: assert property (
      !WR_I |=> $stable({INFRARED_ROUTE_O, PORT_SOFT_RESET_O, ECHO_MASK_O}))
      else $error("control bit moved");
   a_irsel_reserved: assert property (
      RD_I && ADDR_I == OFS_IRSEL |=> RDATA_O[7:1] == 7'h00)
      else $error("reserved bits read back");
   a_timeout_pulse: assert property (
      ACTIVITY_TIMEOUT_O |=> !ACTIVITY_TIMEOUT_O) else $error("pulse");
endmodule // spac_aux_asserts

bind spac_aux_regs spac_aux_asserts u_chk (.*);

// *** test/spac_modem_peer.sv ***
// Modem-side model driving the four active-low handshake pins.
module spac_modem_peer (
   input  wire logic       clk_i,
   input  wire logic       slow_i,
   input  wire logic [3:0] assert_i,
   output logic      [3:0] pins_n_o = 4'hf
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [3:0] hold_q = 4'hf;
   // Lines idle high; slow mode answers one cycle late.
   always @(posedge clk_i) begin
      hold_q   <= ~assert_i;
      pins_n_o <= slow_i ? hold_q : ~assert_i;
   end
endmodule // spac_modem_peer

// *** test/serial_port_aux_control_test.sv ***
// Self-checking bench of the auxiliary register block.
module serial_port_aux_control_test
   import spac_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic CLOCK_I = 0, RESET_I = 1, WR_I = 0, RD_I = 0, PORT_IRQ_ENABLE_I = 0;
   logic [27:0] ADDR_I = '0;
   logic [7:0]  WDATA_I = '0, RDATA_O, d;
   wire logic   CARRIER_DETECT_N_I, BELL_INDICATOR_N_I;
   wire logic   PEER_READY_N_I, CLEAR_TO_SEND_N_I;
   logic INFRARED_ROUTE_O, PORT_SOFT_RESET_O, ECHO_MASK_O;
   logic MODEM_IRQ_O, ACTIVITY_TIMEOUT_O, IRQ_O;
   logic [3:0]  want = '0, prev = '0;
   logic [4:0]  evt = '0;
   logic        slow = 0;
   int          bad_count = 0, n_compared = 0, tmo = 0, n;
   int          pos[5] = '{5, 4, 3, 2, 0};
   logic [27:0] wa[4] = '{OFS_SRESET, OFS_ECHO, OFS_ACTMSK, 28'hc00000b};
   logic [7:0]  we[4] = '{8'h01, 8'h01, 8'h3d, 8'h00};
   logic [27:0] offs[6] = '{OFS_SPARE, OFS_IRSEL, OFS_SRESET, OFS_ECHO,
                            OFS_ACTMSK, OFS_PERIOD};

   always #25 CLOCK_I = ~CLOCK_I;
   always @(posedge CLOCK_I) if (ACTIVITY_TIMEOUT_O === 1'b1) tmo++;

   spac_modem_peer u_peer (.clk_i(CLOCK_I), .slow_i(slow), .assert_i(want),
      .pins_n_o({CARRIER_DETECT_N_I, BELL_INDICATOR_N_I, PEER_READY_N_I,
                 CLEAR_TO_SEND_N_I}));
   spac_aux_regs #(.UNIT_CYCLES(4)) u_dut (.*, .RX_LINE_EDGE_I(evt[4]),
      .REQUEST_SEND_EDGE_I(evt[3]), .CARRIER_EDGE_I(evt[2]),
      .TERMINAL_READY_EDGE_I(evt[1]), .TX_BUFFER_WRITE_I(evt[0]));

   function automatic logic [7:0] exp_ms(logic [3:0] p, logic [3:0] c);
      return {c, p ^ c};
   endfunction
   task automatic chk(string nm, logic [7:0] e, logic [7:0] s);
      n_compared++;
      if (s !== e) begin
         $display("[FAIL] %s expected %h seen %h", nm, e, s);
         bad_count++;
      end
   endtask
   task automatic wr(logic [27:0] a, logic [7:0] v);
      @(posedge CLOCK_I);
      ADDR_I  <= a;
      WDATA_I <= v;
      WR_I    <= 1'b1;
      @(posedge CLOCK_I);
      WR_I <= 1'b0;
   endtask
   task automatic rc(logic [27:0] a, logic [7:0] e, string nm);
      @(posedge CLOCK_I);
      ADDR_I <= a;
      RD_I   <= 1'b1;
      @(posedge CLOCK_I);
      RD_I <= 1'b0;
      #1 chk(nm, e, RDATA_O);
   endtask
   task automatic fire(logic [4:0] e);
      @(posedge CLOCK_I);
      evt <= e;
      @(posedge CLOCK_I);
      evt <= 5'h00;
      repeat (12) @(posedge CLOCK_I);
   endtask
   task automatic final_report();
      $display("compared %0d mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask

   initial begin
      repeat (5000) @(posedge CLOCK_I);
      bad_count++;
      final_report();
   end

   initial begin
      d = 8'($urandom(78));
      repeat (2) @(posedge CLOCK_I);
      RESET_I <= 1'b0;
      foreach (offs[i]) rc(offs[i], 8'h00, "reset value");
      chk("ctl pins", 8'h00, {5'h0, INFRARED_ROUTE_O, PORT_SOFT_RESET_O,
          ECHO_MASK_O});
      d = 8'($urandom);
      wr(OFS_SPARE, d);
      rc(OFS_SPARE, d, "spare");
      wr(OFS_IRSEL, 8'hd3);
      rc(OFS_IRSEL, 8'h01, "route");
      foreach (wa[i]) wr(wa[i], 8'hff);
      foreach (wa[i]) rc(wa[i], we[i], "write ones");
      chk("ctl pins", 8'h07, {5'h0, INFRARED_ROUTE_O, PORT_SOFT_RESET_O,
          ECHO_MASK_O});
      wr(OFS_SRESET, 8'h00);
      wr(OFS_IRSEL, 8'h00);
      for (int i = 0; i < 4; i++) begin
         wr(OFS_IRQ_MASK, {7'h0, ~i[1]});
         @(posedge CLOCK_I);
         slow <= i[1];
         PORT_IRQ_ENABLE_I <= ~i[0];
         want <= (i == 0) ? 4'hf : want ^ (4'($urandom) | 4'h1);
         repeat (8) @(posedge CLOCK_I);
         chk("modem irq", {7'h0, ~i[0]}, {7'h0, MODEM_IRQ_O});
         chk("irq", {7'h0, ~i[1]}, {7'h0, IRQ_O});
         rc(OFS_MODEM, exp_ms(prev, want), "modem status");
         rc(OFS_MODEM, exp_ms(want, want), "modem again");
         rc(OFS_IRQ_STAT, 8'h01, "irq status");
         chk("irq cleared", 8'h00, {7'h0, IRQ_O});
         prev = want;
      end
      wr(OFS_PERIOD, 8'h01);
      for (int k = 0; k < 5; k++) begin
         wr(OFS_ACTMSK, 8'h3d & ~(8'h01 << pos[k]));
         n = tmo;
         fire(5'h1f & ~(5'h10 >> k));
         chk("masked events", 8'(n), 8'(tmo));
         fire(5'h10 >> k);
         chk("unmasked event", 8'(n + 1), 8'(tmo));
      end
      // Zeroing the period while a count runs must stop the expiry.
      n = tmo;
      @(posedge CLOCK_I);
      evt <= 5'h1f;
      @(posedge CLOCK_I);
      evt <= 5'h00;
      wr(OFS_PERIOD, 8'h00);
      repeat (12) @(posedge CLOCK_I);
      chk("timer off", 8'(n), 8'(tmo));
      fire(5'h1f);
      chk("timer idle", 8'(n), 8'(tmo));
      rc(OFS_IRQ_STAT, 8'h02, "timeout status");
      final_report();
   end
endmodule // serial_port_aux_control_test
